/* File: core/uhp_pkg.sv */
// constants and carrier types shared by the host port and modem pin logic
// assumes a single 40 MHz clock; all pins arrive synchronous to it
package uhp_pkg;

	// ****************************************
	// register selects
	// ****************************************
	localparam logic [2:0] ADDR_DIV_LO     = 3'h0;
	localparam logic [2:0] ADDR_IRQ_EN     = 3'h1;
	localparam logic [2:0] ADDR_LINE_CTRL  = 3'h3;
	localparam logic [2:0] ADDR_MODEM_CTRL = 3'h4;
	localparam logic [2:0] ADDR_MODEM_STAT = 3'h6;

	// ****************************************
	// field positions
	// ****************************************
	localparam int MSR_CTS_CHG  = 0;
	localparam int MSR_DSR_CHG  = 1;
	localparam int MSR_DCD_CHG  = 3;
	localparam int MSR_CTS_LVL  = 4;
	localparam int MSR_DSR_LVL  = 5;
	localparam int MSR_DCD_LVL  = 7;
	localparam int MCR_DTR      = 0;
	localparam int MCR_RTS      = 1;
	localparam int MCR_LOOP     = 4;
	localparam int MCR_AFE      = 5;
	localparam int IER_RX_DATA  = 0;
	localparam int IER_THR      = 1;
	localparam int IER_LINE     = 2;
	localparam int IER_MODEM    = 3;
	localparam int LCR_DLAB     = 7;

	// ****************************************
	// reset values and masks
	// ****************************************
	localparam logic [7:0]  IER_RST   = 8'h00;
	localparam logic [7:0]  LCR_RST   = 8'h00;
	localparam logic [7:0]  MCR_RST   = 8'h00;
	localparam logic [7:0]  MSR_RST   = 8'h00;
	localparam logic [7:0]  BYTE_ZERO = 8'h00;
	localparam logic [7:0]  IER_MASK  = 8'h0F;
	localparam logic [7:0]  MCR_MASK  = 8'h3F;
	localparam logic [15:0] DIV_RST   = 16'h0001;
	localparam logic [15:0] DIV_ONE   = 16'h0001;
	localparam logic [15:0] DIV_ZERO  = 16'h0000;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic dcd_n;
		logic dsr_n;
		logic cts_n;
	} uhp_mdm_t;

	typedef struct packed {
		logic [2:0] reg_sel;
		logic       cs_hi_a;
		logic       cs_hi_b;
		logic       cs_lo_n;
	} uhp_sel_t;

endpackage

/* File: core/uhp_baud_gen.sv */
// baud generator: one-cycle 16x enable pulse every divisor clocks
// assumes divisor is static while used; zero stops the pulse train
`timescale 1ns/1ps
`default_nettype none
module uhp_baud_gen #(
	parameter int DIV_W = 16
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst,
	// divisor latch value
	input  wire logic [DIV_W-1:0] divisor,
	// 16x enable
	output var  logic             tick_r
);

	logic [DIV_W-1:0] cnt_r;
	logic [DIV_W-1:0] cnt_nxt;
	logic             tick_nxt;

	always_comb begin
		cnt_nxt  = cnt_r;
		tick_nxt = 1'h0;
		if (divisor == DIV_W'(uhp_pkg::DIV_ZERO)) begin
			cnt_nxt = DIV_W'(uhp_pkg::DIV_ZERO);
		end else if (cnt_r <= DIV_W'(uhp_pkg::DIV_ONE)) begin
			// reload also catches a count left at zero by reset or a zero divisor
			cnt_nxt  = divisor;
			tick_nxt = 1'h1;
		end else begin
			cnt_nxt = cnt_r - DIV_W'(uhp_pkg::DIV_ONE);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cnt_r  <= DIV_W'(uhp_pkg::DIV_ZERO);
			tick_r <= 1'h0;
		end else begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	baud_space_a: assert property (@(posedge clock) disable iff (rst)
		(tick_r && divisor > DIV_W'(uhp_pkg::DIV_ONE) && $stable(divisor)) |=> !tick_r)
		else $error("baud pulse repeated inside one divisor period");

endmodule
`default_nettype wire

/* File: core/uhp_host_port.sv */
// host port, modem control and modem status pins of the serial element
// assumes all pins synchronous to clock; strobes are already decoded to
// active-high read and write levels; other interrupt sources arrive as levels
// Functional notes
// - register selects choose the accessed register
// - low strobe passes selects, high holds captured
// - selected only when both high, low chip selects
// - status bit 4 clear-to-send, bit 0 changed
// - clear-to-send change interrupts unless automatic mode
// - automatic mode: clear-to-send gates new characters
// - status bit 7 carrier, bit 3 changed
// - status bit 5 data-set-ready, bit 1 changed
// - change flags stick until status register read
// - carrier or data-set-ready change raises interrupt
// - control bit set drives terminal-ready active
// - terminal-ready inactive on reset, loopback, clear
// - driver disable high unless host is reading
// - interrupt for any enabled one of four
// - interrupt drops when serviced or reset
// - master reset clears registers except the divisor, and outputs
// - baud pulse at 16x from divisor latches
// - eight-bit data bus driven only during reads
// - control bits 5 and 1 enable autoflow
`timescale 1ns/1ps
`default_nettype none
module uhp_host_port #(
	parameter int DIV_W = 16
) (
	// clock and resets
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       master_reset_in,
	// host select pins
	input  wire logic       reg_select_bit0,
	input  wire logic       reg_select_bit1,
	input  wire logic       reg_select_bit2,
	input  wire logic       addr_strobe_n,
	input  wire logic       chip_sel_hi_a,
	input  wire logic       chip_sel_hi_b,
	input  wire logic       chip_sel_lo_n,
	input  wire logic       rd_strobe,
	input  wire logic       wr_strobe,
	// host data bus
	input  wire logic [7:0] data_in,
	output var  logic [7:0] data_out_r,
	output var  logic       data_oe_r,
	output var  logic       xcvr_disable_r,
	output var  logic       irq_out_r,
	// other interrupt sources of the element
	input  wire logic       rx_line_err_in,
	input  wire logic       rx_data_avail_in,
	input  wire logic       thr_empty_in,
	// modem pins
	input  wire logic       cts_n,
	input  wire logic       dsr_n,
	input  wire logic       carrier_detect_n,
	output var  logic       dtr_n_r,
	// transmitter hooks
	output var  logic       tx_start_ok_r,
	output var  logic       auto_rts_en_r,
	output var  logic       tx_16x_clock_out
);

	// ****************************************
	// select capture
	// ****************************************
	uhp_pkg::uhp_sel_t sel_pins;
	uhp_pkg::uhp_sel_t sel_live;
	uhp_pkg::uhp_sel_t sel_hold_r;
	uhp_pkg::uhp_sel_t sel_hold_nxt;
	logic              clr;
	logic              cs_ok;
	logic              rd_act;
	logic              wr_act;
	logic              rd_prev_r;
	logic              wr_prev_r;
	logic              rd_start;
	logic              wr_start;

	assign clr      = rst | master_reset_in;
	assign sel_pins = '{reg_sel: {reg_select_bit2, reg_select_bit1, reg_select_bit0},
		cs_hi_a: chip_sel_hi_a, cs_hi_b: chip_sel_hi_b, cs_lo_n: chip_sel_lo_n};

	always_comb begin
		// holding tracks the pins while strobe is low, so it keeps the rising-edge value
		sel_hold_nxt = addr_strobe_n ? sel_hold_r : sel_pins;
		sel_live     = addr_strobe_n ? sel_hold_r : sel_pins;
	end

	assign cs_ok    = sel_live.cs_hi_a & sel_live.cs_hi_b & ~sel_live.cs_lo_n;
	assign rd_act   = rd_strobe & cs_ok;
	assign wr_act   = wr_strobe & cs_ok & ~rd_strobe;
	assign rd_start = rd_act & ~rd_prev_r;
	assign wr_start = wr_act & ~wr_prev_r;

	always_ff @(posedge clock) begin
		if (rst) begin
			sel_hold_r <= '0;
			rd_prev_r  <= 1'h0;
			wr_prev_r  <= 1'h0;
		end else begin
			sel_hold_r <= sel_hold_nxt;
			rd_prev_r  <= rd_act;
			wr_prev_r  <= wr_act;
		end
	end

	// ****************************************
	// modem input synchroniser
	// ****************************************
	uhp_pkg::uhp_mdm_t mdm_s1_r;
	uhp_pkg::uhp_mdm_t mdm_s2_r;
	uhp_pkg::uhp_mdm_t mdm_lvl_r;
	uhp_pkg::uhp_mdm_t mdm_chg;

	// change is seen between the second stage and the settled copy only
	assign mdm_chg = mdm_s2_r ^ mdm_lvl_r;

	always_ff @(posedge clock) begin
		if (rst) begin
			mdm_s1_r  <= '1;
			mdm_s2_r  <= '1;
			mdm_lvl_r <= '1;
		end else begin
			mdm_s1_r  <= '{dcd_n: carrier_detect_n, dsr_n: dsr_n, cts_n: cts_n};
			mdm_s2_r  <= mdm_s1_r;
			mdm_lvl_r <= mdm_s2_r;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	logic [7:0]       ier_r, ier_nxt;
	logic [7:0]       lcr_r, lcr_nxt;
	logic [7:0]       mcr_r, mcr_nxt;
	logic [DIV_W-1:0] div_r, div_nxt;
	logic             cts_chg_r, cts_chg_nxt;
	logic             dsr_chg_r, dsr_chg_nxt;
	logic             dcd_chg_r, dcd_chg_nxt;
	logic [7:0]       msr_val;
	logic [7:0]       rd_val;
	logic             msr_rd;
	logic             auto_cts;
	logic             ms_irq;
	logic [7:0]       data_out_nxt;
	logic             irq_nxt;
	logic             dtr_n_nxt;
	logic             tx_ok_nxt;
	logic             auto_rts_nxt;

	assign msr_rd   = rd_start && (sel_live.reg_sel == uhp_pkg::ADDR_MODEM_STAT);
	assign auto_cts = mcr_r[uhp_pkg::MCR_AFE];

	always_comb begin
		msr_val                       = uhp_pkg::MSR_RST;
		msr_val[uhp_pkg::MSR_CTS_LVL] = ~mdm_lvl_r.cts_n;
		msr_val[uhp_pkg::MSR_CTS_CHG] = cts_chg_r;
		msr_val[uhp_pkg::MSR_DSR_LVL] = ~mdm_lvl_r.dsr_n;
		msr_val[uhp_pkg::MSR_DSR_CHG] = dsr_chg_r;
		msr_val[uhp_pkg::MSR_DCD_LVL] = ~mdm_lvl_r.dcd_n;
		msr_val[uhp_pkg::MSR_DCD_CHG] = dcd_chg_r;
	end

	always_comb begin
		// data, line status and ident registers live elsewhere and read zero here
		case (sel_live.reg_sel)
			uhp_pkg::ADDR_DIV_LO:     rd_val = lcr_r[uhp_pkg::LCR_DLAB] ? div_r[7:0]
				: uhp_pkg::BYTE_ZERO;
			uhp_pkg::ADDR_IRQ_EN:     rd_val = lcr_r[uhp_pkg::LCR_DLAB] ? div_r[15:8] : ier_r;
			uhp_pkg::ADDR_LINE_CTRL:  rd_val = lcr_r;
			uhp_pkg::ADDR_MODEM_CTRL: rd_val = mcr_r;
			uhp_pkg::ADDR_MODEM_STAT: rd_val = msr_val;
			default:                  rd_val = uhp_pkg::BYTE_ZERO;
		endcase
	end

	always_comb begin
		ier_nxt = ier_r;
		lcr_nxt = lcr_r;
		mcr_nxt = mcr_r;
		div_nxt = div_r;
		if (wr_start) begin
			case (sel_live.reg_sel)
				uhp_pkg::ADDR_DIV_LO: begin
					if (lcr_r[uhp_pkg::LCR_DLAB]) begin
						div_nxt[7:0] = data_in;
					end
				end
				uhp_pkg::ADDR_IRQ_EN: begin
					if (lcr_r[uhp_pkg::LCR_DLAB]) begin
						div_nxt[15:8] = data_in;
					end else begin
						ier_nxt = data_in & uhp_pkg::IER_MASK;
					end
				end
				uhp_pkg::ADDR_LINE_CTRL:  lcr_nxt = data_in;
				uhp_pkg::ADDR_MODEM_CTRL: mcr_nxt = data_in & uhp_pkg::MCR_MASK;
				default:                  ier_nxt = ier_r;
			endcase
		end
		// a change in the reading cycle survives the clear
		cts_chg_nxt = mdm_chg.cts_n | (cts_chg_r & ~msr_rd);
		dsr_chg_nxt = mdm_chg.dsr_n | (dsr_chg_r & ~msr_rd);
		dcd_chg_nxt = mdm_chg.dcd_n | (dcd_chg_r & ~msr_rd);
	end

	always_ff @(posedge clock) begin
		if (clr) begin
			ier_r     <= uhp_pkg::IER_RST;
			lcr_r     <= uhp_pkg::LCR_RST;
			mcr_r     <= uhp_pkg::MCR_RST;
			cts_chg_r <= 1'h0;
			dsr_chg_r <= 1'h0;
			dcd_chg_r <= 1'h0;
		end else begin
			ier_r     <= ier_nxt;
			lcr_r     <= lcr_nxt;
			mcr_r     <= mcr_nxt;
			cts_chg_r <= cts_chg_nxt;
			dsr_chg_r <= dsr_chg_nxt;
			dcd_chg_r <= dcd_chg_nxt;
		end
	end

	// divisor survives master reset so the baud rate is kept
	always_ff @(posedge clock) begin
		if (rst) begin
			div_r <= DIV_W'(uhp_pkg::DIV_RST);
		end else begin
			div_r <= div_nxt;
		end
	end

	// ****************************************
	// pin outputs
	// ****************************************
	always_comb begin
		ms_irq = (cts_chg_r & ~auto_cts) | dsr_chg_r | dcd_chg_r;
		// sources are levels, so the output drops once every enabled one is serviced
		irq_nxt = (ier_r[uhp_pkg::IER_MODEM] & ms_irq)
			| (ier_r[uhp_pkg::IER_RX_DATA] & rx_data_avail_in)
			| (ier_r[uhp_pkg::IER_THR] & thr_empty_in)
			| (ier_r[uhp_pkg::IER_LINE] & rx_line_err_in);
		dtr_n_nxt    = ~(mcr_r[uhp_pkg::MCR_DTR] & ~mcr_r[uhp_pkg::MCR_LOOP]);
		tx_ok_nxt    = ~auto_cts | ~mdm_lvl_r.cts_n;
		auto_rts_nxt = mcr_r[uhp_pkg::MCR_AFE] & mcr_r[uhp_pkg::MCR_RTS];
		data_out_nxt = rd_start ? rd_val : data_out_r;
	end

	always_ff @(posedge clock) begin
		if (clr) begin
			data_out_r     <= uhp_pkg::BYTE_ZERO;
			data_oe_r      <= 1'h0;
			xcvr_disable_r <= 1'h1;
			irq_out_r      <= 1'h0;
			dtr_n_r        <= 1'h1;
			tx_start_ok_r  <= 1'h1;
			auto_rts_en_r  <= 1'h0;
		end else begin
			data_out_r     <= data_out_nxt;
			data_oe_r      <= rd_act;
			xcvr_disable_r <= ~rd_act;
			irq_out_r      <= irq_nxt;
			dtr_n_r        <= dtr_n_nxt;
			tx_start_ok_r  <= tx_ok_nxt;
			auto_rts_en_r  <= auto_rts_nxt;
		end
	end

	uhp_baud_gen #(
		.DIV_W (DIV_W)
	) u_baud (
		.clock   (clock),
		.rst     (clr),
		.divisor (div_r),
		.tick_r  (tx_16x_clock_out)
	);

	// ****************************************
	// checks
	// ****************************************
	sequence msr_read_s;
		msr_rd && !mdm_chg.dcd_n;
	endsequence

	sequence held_strobe_s;
		addr_strobe_n ##1 addr_strobe_n;
	endsequence

	select_hold_a: assert property (@(posedge clock) disable iff (clr)
		held_strobe_s |-> $stable(sel_hold_r))
		else $error("held selects moved while strobe high");
	chip_sel_a: assert property (@(posedge clock) disable iff (clr)
		!cs_ok |=> !data_oe_r && $stable(mcr_r) && $stable(ier_r))
		else $error("access taken while not selected");
	dcd_flag_a: assert property (@(posedge clock) disable iff (clr)
		mdm_chg.dcd_n |=> dcd_chg_r ##1 (dcd_chg_r || $past(msr_rd)))
		else $error("carrier change flag not set");
	flag_clear_a: assert property (@(posedge clock) disable iff (clr)
		msr_read_s |=> !dcd_chg_r)
		else $error("carrier change flag not cleared by read");
	auto_cts_irq_a: assert property (@(posedge clock) disable iff (clr)
		(auto_cts && !dsr_chg_r && !dcd_chg_r && !rx_data_avail_in && !thr_empty_in
			&& !rx_line_err_in) |=> !irq_out_r)
		else $error("clear-to-send raised interrupt in automatic mode");
	dsr_irq_a: assert property (@(posedge clock) disable iff (clr)
		(dsr_chg_r && ier_r[uhp_pkg::IER_MODEM]) |=> irq_out_r)
		else $error("data-set-ready change gave no interrupt");
	tx_gate_a: assert property (@(posedge clock) disable iff (clr)
		(auto_cts && mdm_lvl_r.cts_n) |=> !tx_start_ok_r)
		else $error("transmit allowed without clear-to-send");
	dtr_loop_a: assert property (@(posedge clock) disable iff (clr)
		mcr_r[uhp_pkg::MCR_LOOP] |=> dtr_n_r)
		else $error("terminal-ready active in loopback");
	dtr_on_a: assert property (@(posedge clock) disable iff (clr)
		(mcr_r[uhp_pkg::MCR_DTR] && !mcr_r[uhp_pkg::MCR_LOOP]) |=> !dtr_n_r)
		else $error("terminal-ready not driven");
	bus_drive_a: assert property (@(posedge clock) disable iff (clr)
		!rd_act |=> xcvr_disable_r && !data_oe_r)
		else $error("bus driven outside a read");
	rx_irq_a: assert property (@(posedge clock) disable iff (clr)
		(ier_r[uhp_pkg::IER_RX_DATA] && rx_data_avail_in) |=> irq_out_r)
		else $error("enabled receive source gave no interrupt");

endmodule
`default_nettype wire

/* File: sim/uhp_modem_model.sv */
// far-side modem model: drives the three active-low status lines
// assumes the bench commands the levels; slow mode lands them up to four clocks late
`timescale 1ns/1ps
`default_nettype none
module uhp_modem_model (
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rst,
	// commanded levels and pace
	input  wire logic              slow,
	input  wire uhp_pkg::uhp_mdm_t want,
	// modem status lines
	output var  uhp_pkg::uhp_mdm_t pins_r
);
	logic [1:0] pace_r;

	always_ff @(posedge clock) begin
		if (rst) begin
			// idle cable reads inactive, as if pulled up
			pins_r <= 3'h7;
			pace_r <= 2'h0;
		end else begin
			pace_r <= pace_r + 2'h1;
			if (!slow || pace_r == 2'h3) begin
				pins_r <= want;
			end
		end
	end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the host port and modem pins
// assumes uhp_pkg and uhp_host_port compiled first; modem lines come from the model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic              clock, rst, mr, asn, rd, wr, slow;
	logic [2:0]        sel, cs, src;
	logic [7:0]        din, data_out_r;
	logic              data_oe_r, xcvr_disable_r, irq_out_r, dtr_n_r, tx_ok, rts_en, baud;
	uhp_pkg::uhp_mdm_t want, pins;
	int                n_fail, samples_checked, cyc_cnt;

	// ****************************************
	// design and far side
	// ****************************************
	uhp_host_port u_dut (
		.clock(clock), .rst(rst), .master_reset_in(mr),
		.reg_select_bit0(sel[0]), .reg_select_bit1(sel[1]), .reg_select_bit2(sel[2]),
		.addr_strobe_n(asn), .chip_sel_hi_a(cs[2]), .chip_sel_hi_b(cs[1]),
		.chip_sel_lo_n(cs[0]), .rd_strobe(rd), .wr_strobe(wr), .data_in(din),
		.data_out_r(data_out_r), .data_oe_r(data_oe_r), .xcvr_disable_r(xcvr_disable_r),
		.irq_out_r(irq_out_r), .rx_line_err_in(src[2]), .rx_data_avail_in(src[0]),
		.thr_empty_in(src[1]), .cts_n(pins.cts_n), .dsr_n(pins.dsr_n),
		.carrier_detect_n(pins.dcd_n), .dtr_n_r(dtr_n_r), .tx_start_ok_r(tx_ok),
		.auto_rts_en_r(rts_en), .tx_16x_clock_out(baud)
	);
	uhp_modem_model u_modem (.clock(clock), .rst(rst), .slow(slow), .want(want), .pins_r(pins));

	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// one host access; reads are judged on the cycle after the taking edge
	task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d, input logic [7:0] e);
		logic on;
		@(posedge clock);
		on = (cs === 3'h6);
		sel <= a;
		din <= d;
		rd <= !w;
		wr <= w;
		@(posedge clock);
		rd <= 1'h0;
		wr <= 1'h0;
		#1;
		if (!w) begin
			chk("bus enable", on, data_oe_r);
			chk("xcvr disable", !on, xcvr_disable_r);
			if (on) chk("read data", e, data_out_r);
		end
		@(posedge clock);
		#1;
		chk("xcvr after access", 1'h1, xcvr_disable_r);
	endtask

	task automatic test_done();
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		wt(1);
		chk("dtr at reset", 1'h1, dtr_n_r);
		chk("irq at reset", 1'h0, irq_out_r);
		acc(1'h0, 3'h6, 8'h00, 8'h00);
		$display("test reset done");
	endtask

	task automatic t_mcr();
		acc(1'h1, 3'h4, 8'h23, 8'h00);
		wt(2);
		chk("dtr set", 1'h0, dtr_n_r);
		chk("autoflow", 1'h1, rts_en);
		acc(1'h1, 3'h4, 8'h13, 8'h00);
		wt(2);
		chk("dtr loop", 1'h1, dtr_n_r);
		chk("autoflow off", 1'h0, rts_en);
		acc(1'h1, 3'h4, 8'h01, 8'h00);
		wt(2);
		chk("dtr again", 1'h0, dtr_n_r);
		acc(1'h1, 3'h4, 8'h00, 8'h00);
		wt(2);
		chk("dtr clear", 1'h1, dtr_n_r);
		$display("test modem control done");
	endtask

	task automatic t_msr();
		acc(1'h1, 3'h1, 8'h08, 8'h00);
		@(posedge clock) want <= 3'h3;
		wt(8);
		chk("irq carrier", 1'h1, irq_out_r);
		acc(1'h0, 3'h6, 8'h00, 8'h88);
		acc(1'h0, 3'h6, 8'h00, 8'h80);
		wt(1);
		chk("irq serviced", 1'h0, irq_out_r);
		// slow modem: the change lands late but must still be caught once
		@(posedge clock) slow <= 1'h1;
		@(posedge clock) want <= 3'h1;
		wt(14);
		acc(1'h0, 3'h6, 8'h00, 8'hA2);
		$display("test modem status done");
	endtask

	task automatic t_cts();
		@(posedge clock) slow <= 1'h0;
		acc(1'h1, 3'h4, 8'h20, 8'h00);
		@(posedge clock) want <= 3'h0;
		wt(8);
		chk("irq auto cts", 1'h0, irq_out_r);
		chk("tx allowed", 1'h1, tx_ok);
		acc(1'h0, 3'h6, 8'h00, 8'hB1);
		@(posedge clock) want <= 3'h1;
		wt(8);
		chk("tx gated", 1'h0, tx_ok);
		acc(1'h0, 3'h6, 8'h00, 8'hA1);
		acc(1'h1, 3'h4, 8'h00, 8'h00);
		chk("irq after auto off", 1'h0, irq_out_r);
		@(posedge clock) want <= 3'h0;
		wt(8);
		chk("irq plain cts", 1'h1, irq_out_r);
		acc(1'h0, 3'h6, 8'h00, 8'hB1);
		$display("test clear to send done");
	endtask

	task automatic t_sel();
		for (int i = 0; i < 3; i++) begin
			@(posedge clock) cs <= 3'h6 ^ (3'h1 << i);
			acc(1'h1, 3'h1, 8'h01, 8'h00);
			acc(1'h0, 3'h1, 8'h00, 8'h00);
		end
		@(posedge clock) cs <= 3'h6;
		acc(1'h0, 3'h1, 8'h00, 8'h08);
		@(posedge clock) sel <= 3'h1;
		@(posedge clock) asn <= 1'h1;
		acc(1'h1, 3'h4, 8'h0A, 8'h00);
		@(posedge clock) asn <= 1'h0;
		acc(1'h0, 3'h1, 8'h00, 8'h0A);
		acc(1'h0, 3'h4, 8'h00, 8'h00);
		$display("test selects done");
	endtask

	task automatic t_irq();
		for (int i = 0; i < 3; i++) begin
			acc(1'h1, 3'h1, 8'h01 << i, 8'h00);
			@(posedge clock) src <= 3'h1 << i;
			wt(3);
			chk("irq source", 1'h1, irq_out_r);
			@(posedge clock) src <= 3'h0;
			wt(3);
			chk("irq source gone", 1'h0, irq_out_r);
		end
		acc(1'h1, 3'h1, 8'h00, 8'h00);
		@(posedge clock) src <= 3'h7;
		wt(3);
		chk("irq masked", 1'h0, irq_out_r);
		$display("test interrupt sources done");
	endtask

	task automatic t_baud();
		int cnt;
		cnt = 0;
		acc(1'h1, 3'h3, 8'h80, 8'h00);
		acc(1'h1, 3'h0, 8'h04, 8'h00);
		acc(1'h1, 3'h1, 8'h00, 8'h00);
		acc(1'h0, 3'h0, 8'h00, 8'h04);
		acc(1'h0, 3'h3, 8'h00, 8'h80);
		acc(1'h1, 3'h3, 8'h00, 8'h00);
		wt(8);
		repeat (40) begin
			@(posedge clock);
			#1;
			cnt += int'(baud);
		end
		chk("baud pulses", 8'h0A, cnt[7:0]);
		$display("test baud done");
	endtask

	task automatic t_mr();
		int cnt;
		cnt = 0;
		acc(1'h1, 3'h1, 8'h04, 8'h00);
		acc(1'h1, 3'h4, 8'h01, 8'h00);
		wt(3);
		chk("irq line error", 1'h1, irq_out_r);
		@(posedge clock) mr <= 1'h1;
		wt(2);
		chk("dtr master reset", 1'h1, dtr_n_r);
		chk("irq master reset", 1'h0, irq_out_r);
		@(posedge clock) mr <= 1'h0;
		acc(1'h0, 3'h1, 8'h00, 8'h00);
		// divisor survives master reset, so the pulse rate must be unchanged
		repeat (40) begin
			@(posedge clock);
			#1;
			cnt += int'(baud);
		end
		chk("baud after master reset", 8'h0A, cnt[7:0]);
		$display("test master reset done");
	endtask

	// ****************************************
	// clock, timeout and main sequence
	// ****************************************
	initial begin
		clock = 1'h0;
		forever #12.5 clock = ~clock;
	end

	always @(posedge clock) begin
		cyc_cnt++;
		if (cyc_cnt == 6000) begin
			n_fail++;
			$display("[FAIL] run length expected below 6000 seen 6000");
			test_done();
		end
	end

	initial begin
		rst = 1'h1;
		mr = 1'h0;
		asn = 1'h0;
		rd = 1'h0;
		wr = 1'h0;
		slow = 1'h0;
		sel = 3'h0;
		cs = 3'h6;
		src = 3'h0;
		din = 8'h00;
		want = 3'h7;
		n_fail = 0;
		samples_checked = 0;
		cyc_cnt = 0;
		repeat (8) @(posedge clock);
		rst <= 1'h0;
		t_reset();
		t_mcr();
		t_msr();
		t_cts();
		t_sel();
		t_irq();
		t_baud();
		t_mr();
		test_done();
	end
endmodule
`default_nettype wire
